// File: irc_carrier_gen.sv
// Carrier generator timer with APB registers and gated output pin.
// Assumes an APB master on CLK_I and a companion timer irq from outside.
//
// How it works
// R1: Software keeps both compare values between one and 255.
// R2: A new high-width value needs three count clocks before it can load.
// R3: Software sets remote output enable before starting the counter.
// R4: Counter stays stopped while the timer enable is zero.
// R5: On start the carrier is held inactive until the first match.
// R6: Low match raises irq, toggles carrier, clears counter, selects high.
// R7: High match raises irq, toggles carrier, clears counter, selects low.
// R8: Equal compare values give a carrier of exactly half duty.
// R9: Companion irq is synchronised to the count clock as a strobe.
// R10: Each strobe copies the master enable into the read-only slave bit.
// R11: Slave low and carrier not high drive the pin low.
// R12: Pin starts passing carrier only at the next carrier rising edge.
// R13: Slave clearing during a high phase keeps the pin high to its end.
// R14: High-width writes while running wait in a latch until a high match.
// R15: That match still acts normally; later high matches use the new value.
// R16: Software also rewrites the high-width value while running.
// R17: Master to slave copy happens two count clocks after the strobe.
// R18: Period is N plus M plus two count clocks, high for M plus one.
// R19: Software rewrites the high-width value at each restart.
// R20: Clearing the enable stops, clears and silences the timer.
// R21: With remote disabled the pin shows the master enable level.
//
// The APB slave port and the register addresses were left to the implementer.
module irc_carrier_gen #(
    parameter int unsigned CNT_W = 8
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic COMPANION_TIMER_IRQ_I,
    input wire logic COMPANION_TIMER_ENABLE_I,
    output logic CARRIER_OUTPUT_PIN_O,
    output logic CARRIER_MATCH_IRQ_O,
    output logic SYNCED_TRANSFER_STROBE_O
);
    if (CNT_W != 8)
    begin : g_bad_cnt
        $error("Only an 8-bit counter is supported");
    end

    irc_pkg::irc_mode_t mode_q;
    irc_pkg::irc_ctrl_t ctrl_q;
    irc_pkg::irc_phase_t phase_q;
    logic [CNT_W-1:0] low_cmp_q;
    logic [CNT_W-1:0] hw_latch_q;
    logic [CNT_W-1:0] hw_active_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cmp_sel;
    logic [1:0] age_q;
    logic hw_pend_q;
    logic carrier_q;
    logic carrier_dly_q;
    logic mask_q;
    logic pass_q;
    logic pass_d;
    logic xfer_pend_q;
    logic arm1_q;
    logic arm2_q;
    logic tick;
    logic comp_rise;
    logic match;
    logic fire;
    logic fire_high;
    logic hw_ready;
    logic acc;
    logic wr_fire;
    logic hit;
    logic [31:0] rd_mux;

    irc_prescale #(
        .DIV_W(irc_pkg::IRC_PRESCALE_W),
        .SEL_W(irc_pkg::IRC_CKS_W)
    ) u_prescale (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .ce_i(CE_I),
        .sel_i(mode_q.count_clock_select),
        .tick_o(tick)
    );

    irc_sync u_sync (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .ce_i(CE_I),
        .async_i(COMPANION_TIMER_IRQ_I),
        .rise_o(comp_rise)
    );

    // APB decode
    assign acc = PSEL_I & PENABLE_I & ~PREADY_O;
    assign wr_fire = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & PSTRB_I[0];
    assign hit = (PADDR_I == irc_pkg::IRC_OFS_MODE)
        | (PADDR_I == irc_pkg::IRC_OFS_LOW)
        | (PADDR_I == irc_pkg::IRC_OFS_HIGH)
        | (PADDR_I == irc_pkg::IRC_OFS_CTRL)
        | (PADDR_I == irc_pkg::IRC_OFS_STAT);

    always_comb
    begin
        rd_mux = irc_pkg::IRC_DATA_RST;
        case (PADDR_I)
            irc_pkg::IRC_OFS_MODE:
            begin
                rd_mux[irc_pkg::IRC_MODE_EN_BIT] = mode_q.carrier_timer_enable;
                rd_mux[irc_pkg::IRC_MODE_CKS_LSB +: irc_pkg::IRC_CKS_W] =
                    mode_q.count_clock_select;
            end
            irc_pkg::IRC_OFS_LOW: rd_mux[CNT_W-1:0] = low_cmp_q;
            irc_pkg::IRC_OFS_HIGH: rd_mux[CNT_W-1:0] = hw_latch_q;
            irc_pkg::IRC_OFS_CTRL:
            begin
                rd_mux[irc_pkg::IRC_CTRL_MASTER_BIT] =
                    ctrl_q.output_enable_master;
                rd_mux[irc_pkg::IRC_CTRL_SLAVE_BIT] =
                    ctrl_q.output_enable_slave;
                rd_mux[irc_pkg::IRC_CTRL_REMOTE_BIT] =
                    ctrl_q.remote_output_enable;
            end
            irc_pkg::IRC_OFS_STAT:
            begin
                rd_mux[CNT_W-1:0] = cnt_q;
                rd_mux[irc_pkg::IRC_STAT_CARRIER_BIT] = carrier_q;
                rd_mux[irc_pkg::IRC_STAT_PHASE_BIT] = (phase_q == irc_pkg::IRC_PH_HIGH);
            end
            default: rd_mux = irc_pkg::IRC_DATA_RST;
        endcase
    end

    // APB answer: ready one cycle into the access phase
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= irc_pkg::IRC_DATA_RST;
        end
        else if (CE_I)
        begin
            PREADY_O <= acc;
            PSLVERR_O <= acc & ~hit;
            if (acc & ~PWRITE_I)
            begin
                PRDATA_O <= rd_mux;
            end
        end
    end

    // Mode, low compare and control registers
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            mode_q <= '0;
            low_cmp_q <= irc_pkg::IRC_CMP_RST;
            ctrl_q.remote_output_enable <= 1'b0;
            ctrl_q.output_enable_master <= 1'b0;
            ctrl_q.output_enable_slave <= 1'b0;
        end
        else if (CE_I)
        begin
            // Slave copy lives here so ctrl_q has a single writer
            if (tick && arm2_q)
            begin
                ctrl_q.output_enable_slave <=
                    ctrl_q.output_enable_master; // [R10] [R17]
            end
            if (wr_fire)
            begin
                case (PADDR_I)
                    irc_pkg::IRC_OFS_MODE:
                    begin
                        mode_q.carrier_timer_enable <=
                            PWDATA_I[irc_pkg::IRC_MODE_EN_BIT];
                        mode_q.count_clock_select <= PWDATA_I[
                            irc_pkg::IRC_MODE_CKS_LSB +: irc_pkg::IRC_CKS_W];
                    end
                    irc_pkg::IRC_OFS_LOW: low_cmp_q <= PWDATA_I[CNT_W-1:0];
                    irc_pkg::IRC_OFS_CTRL:
                    begin
                        ctrl_q.remote_output_enable <=
                            PWDATA_I[irc_pkg::IRC_CTRL_REMOTE_BIT];
                        ctrl_q.output_enable_master <=
                            PWDATA_I[irc_pkg::IRC_CTRL_MASTER_BIT];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Compare selection and match
    always_comb
    begin
        case (phase_q)
            irc_pkg::IRC_PH_LOW: cmp_sel = low_cmp_q;
            irc_pkg::IRC_PH_HIGH: cmp_sel = hw_active_q;
            default: cmp_sel = low_cmp_q;
        endcase
    end
    assign match = (cnt_q == cmp_sel);
    assign fire = mode_q.carrier_timer_enable & tick & ~mask_q & match;
    assign fire_high = fire & (phase_q == irc_pkg::IRC_PH_HIGH);
    assign hw_ready = hw_pend_q
        & (age_q >= 2'(irc_pkg::IRC_HW_SETTLE_TICKS - 1)); // [R2]

    // Counter, carrier and match irq; N+1 then M+1 ticks per phase
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            cnt_q <= '0;
            carrier_q <= 1'b0;
            phase_q <= irc_pkg::IRC_PH_LOW;
            mask_q <= 1'b1;
            CARRIER_MATCH_IRQ_O <= 1'b0;
        end
        else if (CE_I)
        begin
            CARRIER_MATCH_IRQ_O <= fire; // [R6] [R7] [R15]
            if (!mode_q.carrier_timer_enable)
            begin
                cnt_q <= '0; // [R4] [R20]
                carrier_q <= 1'b0; // [R5] [R20]
                phase_q <= irc_pkg::IRC_PH_LOW;
                mask_q <= 1'b1;
            end
            else if (tick)
            begin
                if (mask_q)
                begin
                    mask_q <= 1'b0;
                end
                else if (match)
                begin
                    cnt_q <= '0; // [R8] [R18]
                    carrier_q <= ~carrier_q;
                    case (phase_q)
                        irc_pkg::IRC_PH_LOW: phase_q <= irc_pkg::IRC_PH_HIGH; // [R6]
                        irc_pkg::IRC_PH_HIGH: phase_q <= irc_pkg::IRC_PH_LOW; // [R7]
                        default: phase_q <= irc_pkg::IRC_PH_LOW;
                    endcase
                end
                else
                begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    // High-width latch and deferred load
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            hw_latch_q <= irc_pkg::IRC_CMP_RST;
            hw_active_q <= irc_pkg::IRC_CMP_RST;
            hw_pend_q <= 1'b0;
            age_q <= 2'b00;
        end
        else if (CE_I)
        begin
            if (wr_fire && PADDR_I == irc_pkg::IRC_OFS_HIGH)
            begin
                hw_latch_q <= PWDATA_I[CNT_W-1:0];
                age_q <= 2'b00;
                if (!mode_q.carrier_timer_enable)
                begin
                    hw_active_q <= PWDATA_I[CNT_W-1:0];
                    hw_pend_q <= 1'b0;
                end
                else
                begin
                    hw_pend_q <= 1'b1; // [R14]
                end
            end
            else
            begin
                if (fire_high && hw_ready)
                begin
                    hw_active_q <= hw_latch_q; // [R14] [R15]
                    hw_pend_q <= 1'b0;
                end
                if (tick && hw_pend_q && !hw_ready)
                begin
                    age_q <= age_q + 2'b01; // [R2]
                end
            end
        end
    end

    // Transfer strobe and master to slave copy
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            xfer_pend_q <= 1'b0;
            SYNCED_TRANSFER_STROBE_O <= 1'b0;
            arm1_q <= 1'b0;
            arm2_q <= 1'b0;
        end
        else if (CE_I)
        begin
            xfer_pend_q <= ~tick
                & (xfer_pend_q | (comp_rise & COMPANION_TIMER_ENABLE_I));
            SYNCED_TRANSFER_STROBE_O <= tick
                & (xfer_pend_q | (comp_rise & COMPANION_TIMER_ENABLE_I)); // [R9]
            if (SYNCED_TRANSFER_STROBE_O)
            begin
                arm1_q <= 1'b1;
            end
            else if (tick && arm1_q)
            begin
                arm1_q <= 1'b0;
            end
            if (tick)
            begin
                arm2_q <= arm1_q & ~SYNCED_TRANSFER_STROBE_O; // [R17]
            end
        end
    end

    // Output gating that never cuts a high pulse
    always_comb
    begin
        pass_d = pass_q;
        if (ctrl_q.output_enable_slave && carrier_q && !carrier_dly_q)
        begin
            pass_d = 1'b1; // [R12]
        end
        else if (!ctrl_q.output_enable_slave && !carrier_q)
        begin
            pass_d = 1'b0; // [R11] [R13]
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            pass_q <= 1'b0;
            carrier_dly_q <= 1'b0;
            CARRIER_OUTPUT_PIN_O <= 1'b0;
        end
        else if (CE_I)
        begin
            pass_q <= pass_d;
            carrier_dly_q <= carrier_q;
            if (ctrl_q.remote_output_enable)
            begin
                CARRIER_OUTPUT_PIN_O <= pass_d & carrier_q; // [R11] [R13]
            end
            else
            begin
                CARRIER_OUTPUT_PIN_O <= ctrl_q.output_enable_master; // [R21]
            end
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_copy_tick;
        CE_I && tick && arm2_q;
    endsequence

    sequence s_low_fire;
        CE_I && fire && phase_q == irc_pkg::IRC_PH_LOW;
    endsequence

    chk_stop_idle: assert property ( // [R4] [R20]
        (CE_I && !mode_q.carrier_timer_enable)
        |=> (cnt_q == '0 && !carrier_q ##1 !CARRIER_MATCH_IRQ_O))
        else $error("Counter not idle while disabled");

    chk_start_low: assert property ( // [R5]
        (CE_I && mode_q.carrier_timer_enable && !carrier_q && !fire)
        |=> !carrier_q)
        else $error("Carrier left inactive level without a match");

    chk_low_match: assert property ( // [R6]
        s_low_fire |=> (cnt_q == '0 && carrier_q != $past(carrier_q)
        && phase_q == irc_pkg::IRC_PH_HIGH && CARRIER_MATCH_IRQ_O))
        else $error("Low match effects missing");

    chk_high_match: assert property ( // [R7]
        (CE_I && fire_high) |=> (cnt_q == '0 && phase_q == irc_pkg::IRC_PH_LOW
        && carrier_q != $past(carrier_q) && CARRIER_MATCH_IRQ_O))
        else $error("High match effects missing");

    chk_hw_hold: assert property ( // [R14]
        (mode_q.carrier_timer_enable && !fire_high
        && !(wr_fire && PADDR_I == irc_pkg::IRC_OFS_HIGH))
        |=> $stable(hw_active_q))
        else $error("Active high value changed without a high match");

    chk_hw_take: assert property ( // [R15] [R2]
        (CE_I && fire_high && hw_ready
        && !(wr_fire && PADDR_I == irc_pkg::IRC_OFS_HIGH))
        |=> (hw_active_q == $past(hw_latch_q) && !hw_pend_q))
        else $error("Latched high value not loaded");

    chk_slave_copy: assert property ( // [R10] [R17]
        s_copy_tick |=> ctrl_q.output_enable_slave
        == $past(ctrl_q.output_enable_master))
        else $error("Slave enable not copied");

    chk_strobe_tick: assert property ( // [R9]
        SYNCED_TRANSFER_STROBE_O |-> $past(tick))
        else $error("Transfer strobe off the count clock");

    chk_pin_low: assert property ( // [R11]
        (CE_I && ctrl_q.remote_output_enable && !ctrl_q.output_enable_slave
        && !carrier_q) |=> !CARRIER_OUTPUT_PIN_O)
        else $error("Pin not low with slave clear");

    chk_no_midpulse: assert property ( // [R12]
        (CE_I && ctrl_q.remote_output_enable && !pass_q
        && !(carrier_q && !carrier_dly_q)) |=> !CARRIER_OUTPUT_PIN_O)
        else $error("Carrier passed mid pulse");

    chk_high_guard: assert property ( // [R13]
        (CE_I && ctrl_q.remote_output_enable && pass_q && carrier_q)
        |=> CARRIER_OUTPUT_PIN_O)
        else $error("High pulse truncated");

    chk_static_pin: assert property ( // [R21]
        (CE_I && !ctrl_q.remote_output_enable)
        |=> CARRIER_OUTPUT_PIN_O == $past(ctrl_q.output_enable_master))
        else $error("Static pin level wrong");

endmodule : irc_carrier_gen

// File: irc_carrier_gen_tb.sv
// Self-checking bench for the carrier generator.
// Assumes the companion model on the irq input and APB as master.
module irc_carrier_gen_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, comp_irq, pin, mirq, strobe;
    logic comp_en = 1'b0;
    logic [31:0] q;
    logic e;
    int error_cnt = 0;
    int samples_checked = 0;
    int it, n, m, l, sc, t, p, s, k;

    always #2.5 clk = ~clk;

    irc_carrier_gen #(.CNT_W(8)) DUT (
        .CLK_I(clk), .NRST_I(nrst), .CE_I(1'b1),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .COMPANION_TIMER_IRQ_I(comp_irq),
        .COMPANION_TIMER_ENABLE_I(comp_en),
        .CARRIER_OUTPUT_PIN_O(pin), .CARRIER_MATCH_IRQ_O(mirq),
        .SYNCED_TRANSFER_STROBE_O(strobe)
    );

    irc_companion_model PARTNER (
        .clk_i(clk), .nrst_i(nrst), .enable_i(comp_en), .irq_o(comp_irq)
    );

    task automatic conclude();
        $display("Checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t value %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t count %0d exp %0d", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int w;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        w = 0;
        do
        begin
            @(posedge clk);
            w++;
        end
        while (pready !== 1'b1 && w < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (w >= 50)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t bus timeout", $time);
            conclude();
        end
    endtask : apb

    task automatic wait_irq(output int cyc);
        cyc = 0;
        do
        begin
            @(posedge clk);
            cyc++;
        end
        while (mirq !== 1'b1 && cyc < 2000);
        if (cyc >= 2000)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t match timeout", $time);
            conclude();
        end
    endtask : wait_irq

    // Counts strobes and irqs and checks every whole pin pulse width
    task automatic mon(input int cyc, input int wd, output int pc,
                       output int sc_o, output int ic);
        int run;
        run = 0;
        pc = 0;
        sc_o = 0;
        ic = 0;
        repeat (cyc)
        begin
            @(posedge clk);
            sc_o += (strobe === 1'b1);
            ic += (mirq === 1'b1);
            if (pin === 1'b1)
                run++;
            else if (run > 0)
            begin
                chk_cnt(run, wd);
                pc++;
                run = 0;
            end
        end
    endtask : mon

    initial
    begin
        void'($urandom(32'h6406));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (it = 0; it < 5; it++)
        begin
            apb(1'b0, 8'(4 * it), 32'h0000_0000);
            chk(q, 32'h0000_0000);
        end
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        apb(1'b1, irc_pkg::IRC_OFS_CTRL, 32'h0000_0001);
        repeat (4) @(posedge clk);
        chk(32'(pin), 32'h0000_0001);
        apb(1'b1, irc_pkg::IRC_OFS_CTRL, 32'h0000_0000);
        repeat (4) @(posedge clk);
        chk(32'(pin), 32'h0000_0000);
        apb(1'b1, irc_pkg::IRC_OFS_CTRL, 32'h0000_0080);
        for (it = 0; it < 2; it++)
        begin
            n = 8 + $urandom_range(7);
            m = (it == 1) ? n : 1 + $urandom_range(14);
            l = (it == 1) ? n : 1 + $urandom_range(14);
            sc = 1 << it;
            apb(1'b1, irc_pkg::IRC_OFS_LOW, 32'(n));
            apb(1'b1, irc_pkg::IRC_OFS_HIGH, 32'(m));
            apb(1'b1, irc_pkg::IRC_OFS_MODE, 32'((it << 4) | 1));
            apb(1'b0, irc_pkg::IRC_OFS_STAT, 32'h0000_0000);
            chk(q & 32'h0000_0100, 32'h0000_0000);
            wait_irq(t);
            wait_irq(t);
            chk_cnt(t, (m + 1) * sc);
            wait_irq(t);
            chk_cnt(t, (n + 1) * sc);
            wait_irq(t);
            chk_cnt(t, (m + 1) * sc);
            apb(1'b1, irc_pkg::IRC_OFS_HIGH, 32'(l));
            wait_irq(t);
            wait_irq(t);
            chk_cnt(t, (m + 1) * sc);
            wait_irq(t);
            wait_irq(t);
            chk_cnt(t, (l + 1) * sc);
            comp_en <= 1'b1;
            apb(1'b1, irc_pkg::IRC_OFS_CTRL, 32'h0000_0081);
            fork
                mon(600, (l + 1) * sc, p, s, k);
                begin
                    repeat (300) @(posedge clk);
                    apb(1'b0, irc_pkg::IRC_OFS_CTRL, 32'h0000_0000);
                    chk(q, 32'h0000_0083);
                    apb(1'b1, irc_pkg::IRC_OFS_CTRL, 32'h0000_0080);
                end
            join
            chk_cnt(int'(p > 0), 1);
            chk_cnt(int'(s > 0), 1);
            chk(32'(pin), 32'h0000_0000);
            apb(1'b0, irc_pkg::IRC_OFS_CTRL, 32'h0000_0000);
            chk(q, 32'h0000_0080);
            comp_en <= 1'b0;
            apb(1'b1, irc_pkg::IRC_OFS_MODE, 32'h0000_0000);
            apb(1'b0, irc_pkg::IRC_OFS_STAT, 32'h0000_0000);
            chk(q, 32'h0000_0000);
            mon(100, 1, p, s, k);
            chk_cnt(k, 0);
            apb(1'b0, irc_pkg::IRC_OFS_STAT, 32'h0000_0000);
            chk(q, 32'h0000_0000);
        end
        conclude();
    end
endmodule : irc_carrier_gen_tb

// File: irc_companion_model.sv
// Companion interval timer model: pulses its interrupt while enabled.
// Assumes the system clock; each pulse spans several count clocks.
module irc_companion_model #(
    parameter int unsigned PERIOD = 64,
    parameter int unsigned WIDTH = 6
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic enable_i,
    output logic irq_o
);
    int unsigned cnt_q;

    // Interval counter, held clear while the companion is stopped
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i || !enable_i)
            cnt_q <= 0;
        else
            cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    end

    // Irq only while enabled, low between pulses
    assign irq_o = enable_i && (cnt_q >= PERIOD - WIDTH);
endmodule : irc_companion_model

// File: irc_pkg.sv
// Shared constants and types for the carrier generator.
// Assumes a single clock domain and an APB register bus.
package irc_pkg;

    // Register byte offsets
    localparam logic [7:0] IRC_OFS_MODE = 8'h00;
    localparam logic [7:0] IRC_OFS_LOW = 8'h04;
    localparam logic [7:0] IRC_OFS_HIGH = 8'h08;
    localparam logic [7:0] IRC_OFS_CTRL = 8'h0C;
    localparam logic [7:0] IRC_OFS_STAT = 8'h10;

    // Field positions
    localparam int unsigned IRC_MODE_EN_BIT = 0;
    localparam int unsigned IRC_MODE_CKS_LSB = 4;
    localparam int unsigned IRC_CKS_W = 3;
    localparam int unsigned IRC_CTRL_MASTER_BIT = 0;
    localparam int unsigned IRC_CTRL_SLAVE_BIT = 1;
    localparam int unsigned IRC_CTRL_REMOTE_BIT = 7;
    localparam int unsigned IRC_STAT_CARRIER_BIT = 8;
    localparam int unsigned IRC_STAT_PHASE_BIT = 9;

    // Reset values
    localparam logic [7:0] IRC_CMP_RST = 8'h00;
    localparam logic [31:0] IRC_DATA_RST = 32'h0000_0000;

    // Timing in count clocks and prescaler width
    localparam int unsigned IRC_HW_SETTLE_TICKS = 3;
    localparam int unsigned IRC_PRESCALE_W = 7;

    typedef struct packed {
        logic [IRC_CKS_W-1:0] count_clock_select;
        logic carrier_timer_enable;
    } irc_mode_t;

    typedef struct packed {
        logic remote_output_enable;
        logic output_enable_slave;
        logic output_enable_master;
    } irc_ctrl_t;

    typedef enum logic [1:0] {
        IRC_PH_LOW = 2'b01,
        IRC_PH_HIGH = 2'b10
    } irc_phase_t;

endpackage : irc_pkg

// File: irc_prescale.sv
// Count clock strobe generator: one pulse every 2**sel system clocks.
// Assumes sel comes from logic on the same clock.
module irc_prescale #(
    parameter int unsigned DIV_W = 7,
    parameter int unsigned SEL_W = 3
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [SEL_W-1:0] sel_i,
    output logic tick_o
);
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] mask;

    if (DIV_W < (1 << SEL_W) - 1)
    begin : g_bad_width
        $error("Prescaler too narrow for select range");
    end

    always_comb
    begin
        mask = '0;
        for (int i = 0; i < DIV_W; i++)
        begin
            mask[i] = (i < int'(sel_i));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            div_q <= '0;
            tick_o <= 1'b0;
        end
        else if (ce_i)
        begin
            div_q <= div_q + 1'b1;
            tick_o <= ((div_q & mask) == mask);
        end
    end

endmodule : irc_prescale

// File: irc_sync.sv
// Two-stage synchroniser with rising-edge pulse output.
// Assumes the input may change at any time relative to clk_i.
module irc_sync (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic async_i,
    output logic rise_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            rise_o <= 1'b0;
        end
        else if (ce_i)
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
            rise_o <= sync_q & ~prev_q;
        end
    end

endmodule : irc_sync
